// ---- irq_accept.sv ----
// Interrupt acceptance logic around the processor flag bits.
// Functional notes
// - Maskable requests blocked while mask gate is 0, considered when 1.
// - Acknowledging any interrupt clears the mask gate to 0.
// - Stack select 0, or an acknowledge in progress, uses handler stack pointer; 1 uses task pointer.
// - Stack select cleared on hardware acknowledge and traps 0 to 31.
// - Processor priority level is 3 bits, levels 0 to 7.
// - Request taken only if its priority strictly exceeds current level.
// - Reserved flag bit should be written 0; read value is undefined.
// - Handler start address comes from the fixed table 0FFDCh-0FFFFh.
// - Acknowledge stacks the state into internal RAM from 00400h up.
`timescale 1ns/1ps
module irq_accept
	import irq_accept_pkg::*;
(
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       reset_n,
	// Peripheral requests
	input  wire logic [NUM_SRC-1:0]         reqPend,
	input  wire logic [NUM_SRC*PRIO_W-1:0]  reqPrio,
	// Software trap
	input  wire logic                       trapExec,
	input  wire logic [TRAP_W-1:0]          trapNum,
	// Flag writes from the core
	input  wire logic                       flagWr,
	input  wire logic                       maskGateIn,
	input  wire logic                       stackSelIn,
	input  wire logic [PRIO_W-1:0]          cpuPriorityLevelIn,
	input  wire logic                       reservedIn,
	// Flag state
	output logic                            maskGate,
	output logic                            stackSel,
	output logic [PRIO_W-1:0]               cpuPriorityLevel,
	output logic                            reservedFlag,
	output logic [SP_W-1:0]                 activeStackPointer,
	output logic [SP_W-1:0]                 handlerStackPointer,
	// Acknowledge
	output logic                            ackPulse,
	output logic [SRC_W-1:0]                ackSrc,
	output logic                            stackWrEn,
	output logic [ADDR_W-1:0]               stackWrAddr,
	output logic                            vecFetchEn,
	output logic [ADDR_W-1:0]               vecAddr,
	output logic                            busy
);
	logic       rstMeta_r;
	logic       rstSync_r;
	prio_if     sel ();
	accept_e    state_r;
	accept_e    state_nxt;
	logic       accept;
	logic       trapClearsSel;
	logic       maskGate_nxt;
	logic       stackSel_nxt;
	logic       reservedFlag_nxt;
	logic [PRIO_W-1:0] cpuPriorityLevel_nxt;
	logic [SP_W-1:0]   handlerStackPointer_nxt;
	logic [SP_W-1:0]   activeStackPointer_nxt;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end

	irq_prio_select uSel (
		.reqPend (reqPend),
		.reqPrio (reqPrio),
		.sel     (sel.arb)
	);

	// Acceptance requires both the gate and strictly higher priority.
	assign accept = (state_r == ST_IDLE) && maskGate &&
		sel.valid && (sel.prio > cpuPriorityLevel);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:  if (accept) state_nxt = ST_STACK;
			ST_STACK: state_nxt = ST_FETCH;
			ST_FETCH: state_nxt = ST_IDLE;
			default:  state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) state_r <= ST_IDLE;
		else state_r <= state_nxt;
	end

	// Trap numbers above the limit leave the stack select alone.
	assign trapClearsSel = trapExec && (trapNum <= TRAP_FLAG_LIMIT);

	// Acceptance overrides a flag write of gate, select and level; a trap overrides the gate, and the select for traps 0 to 31.
	always_comb begin
		maskGate_nxt         = maskGate;
		stackSel_nxt         = stackSel;
		cpuPriorityLevel_nxt = cpuPriorityLevel;
		reservedFlag_nxt     = reservedFlag;
		if (flagWr) begin
			maskGate_nxt         = maskGateIn;
			stackSel_nxt         = stackSelIn;
			cpuPriorityLevel_nxt = cpuPriorityLevelIn;
			reservedFlag_nxt     = reservedIn;
		end
		if (accept) begin
			maskGate_nxt         = 1'b0;
			stackSel_nxt         = 1'b0;
			cpuPriorityLevel_nxt = sel.prio;
		end else if (trapExec) begin
			maskGate_nxt = 1'b0;
			if (trapClearsSel) begin
				stackSel_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			maskGate <= MASK_GATE_RST;
		end else begin
			maskGate <= maskGate_nxt;
		end
	end

	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			stackSel <= STACK_SEL_RST;
		end else begin
			stackSel <= stackSel_nxt;
		end
	end

	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			cpuPriorityLevel <= PRIO_RST;
		end else begin
			cpuPriorityLevel <= cpuPriorityLevel_nxt;
		end
	end

	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			reservedFlag <= 1'b0;
		end else begin
			reservedFlag <= reservedFlag_nxt;
		end
	end

	// One frame is taken from the handler stack while stacking.
	always_comb begin
		handlerStackPointer_nxt = handlerStackPointer;
		if (state_r == ST_STACK) begin
			handlerStackPointer_nxt = handlerStackPointer - FRAME_BYTES;
		end
	end

	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			handlerStackPointer <= HSP_RST;
		end else begin
			handlerStackPointer <= handlerStackPointer_nxt;
		end
	end

	// The task pointer has no load path, so it keeps its reset value.
	// Next values are used so the output agrees with the flags it shows.
	always_comb begin
		if (state_nxt != ST_IDLE || stackSel_nxt == 1'b0) begin
			activeStackPointer_nxt = handlerStackPointer_nxt;
		end else begin
			activeStackPointer_nxt = TSP_RST;
		end
	end

	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			activeStackPointer <= HSP_RST;
		end else begin
			activeStackPointer <= activeStackPointer_nxt;
		end
	end

	// Acknowledge strobes are registered from the next state, so they line up with the sequencer state.
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			ackPulse   <= 1'b0;
			stackWrEn  <= 1'b0;
			vecFetchEn <= 1'b0;
			busy       <= 1'b0;
		end else begin
			ackPulse   <= accept;
			stackWrEn  <= (state_nxt == ST_STACK);
			vecFetchEn <= (state_nxt == ST_FETCH);
			busy       <= (state_nxt != ST_IDLE);
		end
	end

	// Source and vector entry stay until the next acceptance.
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			ackSrc  <= '0;
			vecAddr <= VEC_TABLE_BASE;
		end else if (accept) begin
			ackSrc  <= sel.src;
			vecAddr <= VEC_TABLE_BASE + VEC_ENTRY_SIZE
				* ADDR_W'(sel.src);
		end
	end

	// Stack frame lands in internal RAM above its base.
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			stackWrAddr <= RAM_BASE;
		end else if (accept) begin
			stackWrAddr <= RAM_BASE + ADDR_W'(handlerStackPointer)
				- ADDR_W'(FRAME_BYTES);
		end
	end
endmodule

// ---- irq_accept_pkg.sv ----
// Package with constants for the interrupt acceptance flag logic.
package irq_accept_pkg;
	localparam int PRIO_W        = 3;
	localparam int NUM_SRC       = 8;
	localparam int SRC_W         = 3;
	localparam int ADDR_W        = 20;
	localparam int SP_W          = 16;
	localparam int TRAP_W        = 6;
	localparam logic [ADDR_W-1:0] VEC_TABLE_BASE = 20'h0ffdc;
	localparam logic [ADDR_W-1:0] VEC_TABLE_LAST = 20'h0ffff;
	localparam logic [ADDR_W-1:0] RAM_BASE       = 20'h00400;
	localparam logic [ADDR_W-1:0] VEC_ENTRY_SIZE = 20'h00004;
	localparam logic [TRAP_W-1:0] TRAP_FLAG_LIMIT = 6'h1f;
	localparam logic              MASK_GATE_RST  = 1'b0;
	localparam logic              STACK_SEL_RST  = 1'b0;
	localparam logic [PRIO_W-1:0] PRIO_RST       = 3'h0;
	localparam logic [SP_W-1:0]   HSP_RST        = 16'h0800;
	localparam logic [SP_W-1:0]   TSP_RST        = 16'h0800;
	localparam logic [SP_W-1:0]   FRAME_BYTES    = 16'h0004;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_STACK = 2'b01,
		ST_FETCH = 2'b10
	} accept_e;
endpackage

// ---- irq_accept_properties.sv ----
// Checker for the interrupt acceptance ports.
`timescale 1ns/1ps
module irq_accept_properties
	import irq_accept_pkg::*;
(
	input wire logic              clk, reset_n, maskGate, stackSel, ackPulse,
	input wire logic              stackWrEn, vecFetchEn, busy, trapExec,
	input wire logic [PRIO_W-1:0] cpuPriorityLevel,
	input wire logic [SRC_W-1:0]  ackSrc,
	input wire logic [TRAP_W-1:0] trapNum,
	input wire logic [ADDR_W-1:0] stackWrAddr, vecAddr,
	input wire logic [SP_W-1:0]   activeStackPointer, handlerStackPointer
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_gate_blocks: assert property (!maskGate |=> !ackPulse)
		else $error("ack while gate closed");
	a_ack_clears: assert property (ackPulse |-> !maskGate && !stackSel)
		else $error("flags not cleared on ack");
	a_level_above: assert property (ackPulse |->
		cpuPriorityLevel > $past(cpuPriorityLevel))
		else $error("ack without higher priority");
	a_ack_seq: assert property (ackPulse |->
		stackWrEn && busy ##1 vecFetchEn ##1 !busy)
		else $error("bad ack sequence");
	a_stack_ram: assert property (stackWrEn |->
		stackWrAddr == RAM_BASE + handlerStackPointer - FRAME_BYTES)
		else $error("bad stack address");
	a_vec_entry: assert property (vecFetchEn |-> vecAddr <= VEC_TABLE_LAST
		&& vecAddr == VEC_TABLE_BASE + 4 * ackSrc)
		else $error("bad vector address");
	a_sp_frame: assert property (vecFetchEn |-> handlerStackPointer
		== $past(handlerStackPointer) - FRAME_BYTES)
		else $error("stack pointer not moved");
	a_sp_select: assert property (!stackSel |->
		activeStackPointer == handlerStackPointer)
		else $error("wrong active stack pointer");
	a_trap_sel: assert property (trapExec && trapNum <= TRAP_FLAG_LIMIT
		|=> !stackSel)
		else $error("trap kept stack select");
endmodule

// ---- irq_prio_select.sv ----
// Picks the highest priority pending request among the sources.
`timescale 1ns/1ps
module irq_prio_select
	import irq_accept_pkg::*;
(
	// Requests
	input  wire logic [NUM_SRC-1:0]        reqPend,
	input  wire logic [NUM_SRC*PRIO_W-1:0] reqPrio,
	// Result
	prio_if.arb                            sel
);
	logic [NUM_SRC:0]           v;
	logic [SRC_W-1:0]           s [NUM_SRC+1];
	logic [PRIO_W-1:0]          p [NUM_SRC+1];
	assign v[0] = 1'b0;
	assign s[0] = '0;
	assign p[0] = '0;
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : gSel
			logic [PRIO_W-1:0] pr;
			logic              take;
			assign pr   = reqPrio[g*PRIO_W +: PRIO_W];
			assign take = reqPend[g] && (!v[g] || pr > p[g]);
			assign v[g+1] = v[g] | reqPend[g];
			assign s[g+1] = take ? SRC_W'(g) : s[g];
			assign p[g+1] = take ? pr : p[g];
		end
	endgenerate
	assign sel.valid = v[NUM_SRC];
	assign sel.src   = s[NUM_SRC];
	assign sel.prio  = p[NUM_SRC];
endmodule

// ---- irq_src_model.sv ----
// Peripheral request sources: a request stays pending until acknowledged.
`timescale 1ns/1ps
module irq_src_model
	import irq_accept_pkg::*;
(
	input wire logic                       clk,
	input wire logic [NUM_SRC-1:0]         raise,
	input wire logic [NUM_SRC*PRIO_W-1:0]  prioSet,
	input wire logic                       ackPulse,
	input wire logic [SRC_W-1:0]           ackSrc,
	output logic     [NUM_SRC-1:0]         reqPend = '0,
	output logic     [NUM_SRC*PRIO_W-1:0]  reqPrio = '0
);
	always @(posedge clk) begin
		reqPend <= (reqPend | raise) & ~({7'h0, ackPulse} << ackSrc);
		reqPrio <= prioSet;
	end
endmodule

// ---- prio_if.sv ----
// Interface carrying the request arbitration result between modules.
`timescale 1ns/1ps
interface prio_if;
	import irq_accept_pkg::*;
	logic                 valid;
	logic [SRC_W-1:0]     src;
	logic [PRIO_W-1:0]    prio;
	modport arb (output valid, output src, output prio);
	modport use_side (input valid, input src, input prio);
endinterface

// ---- testbench.sv ----
// Self-checking bench for the interrupt acceptance logic.
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin fails++; \
	$display("wrong value at %0t: %h %h", $time, a, b); end end
module testbench;
	import irq_accept_pkg::*;
	logic clk = 0, reset_n = 0, trapExec = 0, flagWr = 0, gIn = 0, selIn = 0;
	logic [2:0] lvIn = 0;
	logic [5:0] trapNum = 0;
	logic [7:0] raise = 0, pend, ackNow;
	logic [23:0] prioSet = 0, reqPrio;
	logic maskGate, stackSel, ackPulse, stackWrEn, vecFetchEn, busy;
	logic resIn = 0, rsvd;
	logic [2:0] cpuPriorityLevel, ackSrc;
	logic [19:0] stackWrAddr, vecAddr;
	logic [15:0] activeStackPointer, handlerStackPointer, expSp;
	int fails = 0, nTests = 0, cyc = 0, best, hsp = 'h800, pe[8], pr[8];
	bit got;
	always #5 clk = ~clk;
	always @(posedge clk) if (++cyc > 2000) begin fails++; report_and_stop; end
	irq_src_model i_irq_src_model (.clk, .raise, .prioSet, .ackPulse, .ackSrc,
		.reqPend(pend), .reqPrio);
	irq_accept i_irq_accept (.clk, .reset_n, .reqPend(pend), .reqPrio,
		.trapExec, .trapNum, .flagWr, .maskGateIn(gIn), .stackSelIn(selIn),
		.cpuPriorityLevelIn(lvIn), .reservedIn(resIn), .maskGate, .stackSel,
		.cpuPriorityLevel, .reservedFlag(rsvd), .activeStackPointer,
		.handlerStackPointer, .ackPulse, .ackSrc, .stackWrEn, .stackWrAddr,
		.vecFetchEn, .vecAddr, .busy);
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", nTests, fails);
		if (fails == 0 && nTests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		pe = '{default: 0};
		void'($urandom(32'h7bccec36));
		repeat (20) @(posedge clk);
		reset_n <= 1;
		repeat (5) @(posedge clk);
		for (int k = 0; k < 60; k++) begin
			ackNow = 8'($urandom % 256) & 8'($urandom % 256);
			for (int i = 0; i < 8; i++) begin
				pr[i] = $urandom % 8;
				prioSet[3*i +: 3] <= 3'(pr[i]);
				pe[i] |= ackNow[i];
			end
			raise <= ackNow;
			@(posedge clk);
			raise <= 0;
			flagWr <= 1;
			gIn <= 1'($urandom % 4 != 0);
			selIn <= 1'($urandom % 2);
			resIn <= 1'b0;
			lvIn <= 3'($urandom % 8);
			@(posedge clk);
			flagWr <= 0;
			best = -1;
			for (int i = 0; i < 8; i++)
				if (pe[i] && pr[i] > lvIn && (best < 0 || pr[i] > pr[best]))
					best = i;
			if (!gIn) best = -1;
			got = 0;
			repeat (6) @(posedge clk) if (ackPulse === 1'b1) got = 1;
			`CHK(got, best >= 0)
			`CHK(maskGate, best < 0 && gIn)
			`CHK(stackSel, best < 0 && selIn)
			`CHK(rsvd, 1'b0)
			`CHK(cpuPriorityLevel, 3'(best < 0 ? lvIn : pr[best]))
			if (best >= 0) begin
				`CHK(ackSrc, 3'(best))
				`CHK(vecAddr, VEC_TABLE_BASE + 20'(4 * best))
				`CHK(stackWrAddr, RAM_BASE + 20'(hsp - 4))
				hsp -= 4;
				pe[best] = 0;
			end
			`CHK(handlerStackPointer, 16'(hsp))
			expSp = (best < 0 && selIn) ? TSP_RST : 16'(hsp);
			`CHK(activeStackPointer, expSp)
			// The trap lands together with a flag write, which loses the mask gate, and stack select for traps 0 to 31.
			trapExec <= 1;
			trapNum <= 6'($urandom % 64);
			flagWr <= 1;
			gIn <= 1;
			selIn <= 1;
			@(posedge clk);
			trapExec <= 0;
			flagWr <= 0;
			@(posedge clk);
			`CHK(stackSel, trapNum > 31)
			`CHK(maskGate, 1'b0)
			`CHK(cpuPriorityLevel, lvIn)
		end
		report_and_stop;
	end
endmodule
bind irq_accept irq_accept_properties i_irq_accept_properties (.clk,
	.reset_n, .maskGate, .stackSel, .ackPulse, .stackWrEn, .vecFetchEn,
	.busy, .trapExec, .cpuPriorityLevel, .ackSrc, .trapNum, .stackWrAddr,
	.vecAddr, .activeStackPointer, .handlerStackPointer);
